// *** core/ufr_regs.sv ***
// How it works
// (RULE_01) Write-only threshold register at 00H appears only when line control is BF; resets to zero.
// (RULE_02) Threshold write bit 7 picks target: 0 receive threshold, 1 transmit threshold.
// (RULE_03) Threshold value comes from bits 6:0; software keeps it within 00 to 40.
// (RULE_04) Read-only fill count at 00H, reset zero, visible only when line control is BF.
// (RULE_05) Fill count bit 7 tells the fifo: 0 receive, 1 transmit.
// (RULE_06) Fill count source alternates between receive and transmit after every read.
// (RULE_07) Fill count bits 6:0 give characters held in the selected fifo.
// (RULE_08) Feature select register at 01H, reset 20H, only when line control is BF.
// (RULE_09) Feature select bits 5:4 choose trigger table A to D; bits 7:6 reserved.
// (RULE_10) Fill counts cover empty to full 64 entries, saturating without wrap.
`timescale 1ns/1ps
module ufr_regs
  import ufr_pkg::*;
(
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_b_i,
  // host access
  input  wire ufr_bus_req_t  bus_req_i,
  input  wire logic [7:0]    line_control_register_i,
  output logic [7:0]         rdata_o,
  output logic               rdata_valid_o,
  // fifo activity
  input  wire ufr_fifo_evt_t rx_evt_i,
  input  wire ufr_fifo_evt_t tx_evt_i,
  // thresholds and table to the trigger logic
  output logic [6:0]         receive_threshold_o,
  output logic [6:0]         transmit_threshold_o,
  output logic [1:0]         table_sel_o,
  // fill levels
  output logic [6:0]         rx_level_o,
  output logic [6:0]         tx_level_o
);

  // largest count a fill level may show
  localparam logic [6:0] FULL_LVL = 7'(FIFO_DEPTH);

  // access decode
  logic            bank_open;
  logic            wr_thr;
  logic            rd_fill;
  logic            wr_feat;
  logic            rd_feat;

  // register state
  logic [6:0]      rx_thr_reg;
  logic [6:0]      rx_thr_next;
  logic [6:0]      tx_thr_reg;
  logic [6:0]      tx_thr_next;
  logic [1:0]      tbl_reg;
  logic [1:0]      tbl_next;
  ufr_src_t        src_reg;
  ufr_src_t        src_next;
  logic [7:0]      rdata_reg;
  logic [7:0]      rdata_next;
  logic            rvalid_reg;
  logic            rvalid_next;

  // fill levels from the counters
  logic [6:0]      rx_level;
  logic [6:0]      tx_level;

  function automatic logic hit(input ufr_bus_req_t req, input logic is_open, input logic [2:0] ofs);
    hit = req.cs && is_open && (req.addr == ofs);
  endfunction

  // enhanced bank is open only on the exact key
  assign bank_open = (line_control_register_i == BANK_KEY); // RULE_01
  assign wr_thr    = hit(bus_req_i, bank_open, OFS_THR_WR) && bus_req_i.wr; // RULE_01
  assign rd_fill   = hit(bus_req_i, bank_open, OFS_FILL) && bus_req_i.rd; // RULE_04
  assign wr_feat   = hit(bus_req_i, bank_open, OFS_FEAT) && bus_req_i.wr; // RULE_08
  assign rd_feat   = hit(bus_req_i, bank_open, OFS_FEAT) && bus_req_i.rd; // RULE_08

  // receive and transmit fill counters
  ufr_level_cnt #(
    .DEPTH (FIFO_DEPTH),
    .W     (LVL_W)
  ) u_rx_cnt (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .evt_i     (rx_evt_i),
    .level_o   (rx_level)
  );

  ufr_level_cnt #(
    .DEPTH (FIFO_DEPTH),
    .W     (LVL_W)
  ) u_tx_cnt (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .evt_i     (tx_evt_i),
    .level_o   (tx_level)
  );

  // threshold writes
  always_comb begin
    rx_thr_next = rx_thr_reg;
    tx_thr_next = tx_thr_reg;
    if (wr_thr) begin
      if (!bus_req_i.wdata[THR_SEL_BIT]) begin // RULE_02
        rx_thr_next = bus_req_i.wdata[THR_VAL_MSB:0]; // RULE_03
      end else begin
        tx_thr_next = bus_req_i.wdata[THR_VAL_MSB:0]; // RULE_03
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rx_thr_reg <= RST_THR; // RULE_01
      tx_thr_reg <= RST_THR;
    end else begin
      rx_thr_reg <= rx_thr_next;
      tx_thr_reg <= tx_thr_next;
    end
  end

  // feature select: only the table field is stored, reserved bits ignored
  always_comb begin
    tbl_next = tbl_reg;
    if (wr_feat) begin
      tbl_next = bus_req_i.wdata[FEAT_TBL_MSB:FEAT_TBL_LSB]; // RULE_09
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      tbl_reg <= RST_FEAT[FEAT_TBL_MSB:FEAT_TBL_LSB]; // RULE_08
    end else begin
      tbl_reg <= tbl_next;
    end
  end

  // level source alternates on each level read
  always_comb begin
    src_next = src_reg;
    if (rd_fill) begin
      unique case (src_reg)
        SRC_RX: src_next = SRC_TX; // RULE_06
        SRC_TX: src_next = SRC_RX; // RULE_06
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      src_reg <= SRC_RX;
    end else begin
      src_reg <= src_next;
    end
  end

  // read data, registered one cycle after the strobe
  always_comb begin
    rdata_next  = rdata_reg;
    rvalid_next = 1'h0;
    if (rd_fill) begin
      rvalid_next = 1'h1;
      rdata_next[FILL_SRC_BIT] = (src_reg == SRC_TX); // RULE_05
      rdata_next[6:0] = (src_reg == SRC_TX) ? tx_level : rx_level; // RULE_07
    end else if (rd_feat) begin
      rvalid_next = 1'h1;
      rdata_next  = '0; // RULE_09
      rdata_next[FEAT_TBL_MSB:FEAT_TBL_LSB] = tbl_reg; // RULE_09
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      rdata_reg  <= RST_RDATA; // RULE_04
      rvalid_reg <= 1'h0;
    end else begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  assign rdata_o              = rdata_reg;
  assign rdata_valid_o        = rvalid_reg;
  assign receive_threshold_o  = rx_thr_reg;
  assign transmit_threshold_o = tx_thr_reg;
  assign table_sel_o          = tbl_reg;
  assign rx_level_o           = rx_level;
  assign tx_level_o           = tx_level;

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_thr_wr_rx;
    wr_thr && !bus_req_i.wdata[THR_SEL_BIT];
  endsequence

  sequence s_thr_wr_tx;
    wr_thr && bus_req_i.wdata[THR_SEL_BIT];
  endsequence

  sequence s_fill_rd;
    bus_req_i.cs && bus_req_i.rd && line_control_register_i == BANK_KEY && bus_req_i.addr == OFS_FILL;
  endsequence

  sequence s_no_rd;
    !rd_fill && !rd_feat;
  endsequence

  sequence s_unmapped_rd;
    bus_req_i.cs && bus_req_i.rd && bus_req_i.addr != OFS_FILL && bus_req_i.addr != OFS_FEAT;
  endsequence

  property p_thr_rx_load;
    s_thr_wr_rx |=> (rx_thr_reg == $past(bus_req_i.wdata[THR_VAL_MSB:0])) && $stable(tx_thr_reg);
  endproperty
  a_thr_rx_load: assert property (p_thr_rx_load) else $error("receive threshold not loaded"); // RULE_02

  property p_thr_tx_load;
    s_thr_wr_tx |=> (tx_thr_reg == $past(bus_req_i.wdata[THR_VAL_MSB:0])) && $stable(rx_thr_reg);
  endproperty
  a_thr_tx_load: assert property (p_thr_tx_load) else $error("transmit threshold not loaded"); // RULE_03

  property p_wr_closed;
    (bus_req_i.cs && bus_req_i.wr && line_control_register_i != BANK_KEY)
      |=> $stable(rx_thr_reg) && $stable(tx_thr_reg) && $stable(tbl_reg);
  endproperty
  a_wr_closed: assert property (p_wr_closed) else $error("write outside bank changed state"); // RULE_01

  property p_thr_hold;
    !wr_thr |=> $stable(rx_thr_reg) && $stable(tx_thr_reg);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold moved without a write"); // RULE_01

  property p_rd_closed;
    (bus_req_i.cs && bus_req_i.rd && line_control_register_i != BANK_KEY) |=> !rdata_valid_o;
  endproperty
  a_rd_closed: assert property (p_rd_closed) else $error("read answered outside bank"); // RULE_04

  property p_unmapped_rd;
    s_unmapped_rd |=> !rdata_valid_o;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped offset answered"); // RULE_04

  property p_no_rd_quiet;
    s_no_rd |=> !rdata_valid_o && $stable(rdata_o);
  endproperty
  a_no_rd_quiet: assert property (p_no_rd_quiet) else $error("read data moved without a read"); // RULE_04

  property p_fill_valid;
    s_fill_rd |=> rdata_valid_o;
  endproperty
  a_fill_valid: assert property (p_fill_valid) else $error("level read not answered"); // RULE_04

  property p_rw_both;
    rd_fill && wr_thr |=> rdata_valid_o;
  endproperty
  a_rw_both: assert property (p_rw_both) else $error("read lost beside a write"); // RULE_04

  property p_rd_reset;
    $rose(rst_b_i) |-> rdata_o == 8'h00 && !rdata_valid_o && src_reg == SRC_RX;
  endproperty
  a_rd_reset: assert property (p_rd_reset) else $error("read side reset values wrong"); // RULE_04

  property p_fill_flag;
    s_fill_rd |=> rdata_valid_o && (rdata_o[FILL_SRC_BIT] == ($past(src_reg) == SRC_TX));
  endproperty
  a_fill_flag: assert property (p_fill_flag) else $error("level source flag wrong"); // RULE_05

  property p_fill_alternate;
    s_fill_rd ##1 s_fill_rd |=> rdata_o[FILL_SRC_BIT] != $past(rdata_o[FILL_SRC_BIT]);
  endproperty
  a_fill_alternate: assert property (p_fill_alternate) else $error("level reads did not alternate"); // RULE_06

  property p_src_toggle;
    rd_fill |=> src_reg != $past(src_reg);
  endproperty
  a_src_toggle: assert property (p_src_toggle) else $error("level source did not toggle"); // RULE_06

  property p_src_hold;
    !rd_fill |=> $stable(src_reg);
  endproperty
  a_src_hold: assert property (p_src_hold) else $error("level source moved without a read"); // RULE_06

  property p_fill_count;
    s_fill_rd |=> rdata_o[6:0] == ($past(src_reg) == SRC_TX ? $past(tx_level) : $past(rx_level));
  endproperty
  a_fill_count: assert property (p_fill_count) else $error("level count wrong"); // RULE_07

  property p_fill_range;
    s_fill_rd |=> rdata_o[6:0] <= FULL_LVL;
  endproperty
  a_fill_range: assert property (p_fill_range) else $error("level count above full"); // RULE_10

  property p_feat_read;
    rd_feat |=> rdata_valid_o && rdata_o == {2'h0, $past(tbl_reg), 4'h0};
  endproperty
  a_feat_read: assert property (p_feat_read) else $error("feature select read wrong"); // RULE_09

  property p_feat_write;
    wr_feat |=> tbl_reg == $past(bus_req_i.wdata[FEAT_TBL_MSB:FEAT_TBL_LSB]);
  endproperty
  a_feat_write: assert property (p_feat_write) else $error("table select not written"); // RULE_09

  property p_feat_hold;
    !wr_feat |=> $stable(tbl_reg);
  endproperty
  a_feat_hold: assert property (p_feat_hold) else $error("table select moved without a write"); // RULE_09

  property p_feat_reset;
    $rose(rst_b_i) |-> tbl_reg == 2'h2 && rx_thr_reg == 7'h00 && tx_thr_reg == 7'h00;
  endproperty
  a_feat_reset: assert property (p_feat_reset) else $error("reset values wrong"); // RULE_08

endmodule

// *** pkg/ufr_pkg.sv ***
package ufr_pkg;

  // bank key and register offsets
  localparam logic [7:0] BANK_KEY      = 8'hBF;
  localparam int         ADDR_W        = 3;
  localparam logic [2:0] OFS_THR_WR    = 3'h0;
  localparam logic [2:0] OFS_FILL      = 3'h0;
  localparam logic [2:0] OFS_FEAT      = 3'h1;

  // field positions
  localparam int         THR_SEL_BIT   = 7;
  localparam int         THR_VAL_MSB   = 6;
  localparam int         FILL_SRC_BIT  = 7;
  localparam int         FEAT_TBL_LSB  = 4;
  localparam int         FEAT_TBL_MSB  = 5;

  // reset values
  localparam logic [6:0] RST_THR       = 7'h00;
  localparam logic [7:0] RST_FEAT      = 8'h20;
  localparam logic [7:0] RST_RDATA     = 8'h00;

  // fifo geometry and largest legal threshold
  localparam int         FIFO_DEPTH    = 64;
  localparam int         LVL_W         = 7;
  localparam logic [6:0] THR_MAX       = 7'h40;

  // host access of one bus cycle
  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ufr_bus_req_t;

  // fifo activity of one cycle
  typedef struct packed {
    logic push;
    logic pop;
  } ufr_fifo_evt_t;

  // which fifo the next level read reports
  typedef enum logic {
    SRC_RX,
    SRC_TX
  } ufr_src_t;

endpackage

// *** core/ufr_level_cnt.sv ***
`timescale 1ns/1ps
module ufr_level_cnt
  import ufr_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH,
  parameter int W     = LVL_W
) (
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rst_b_i,
  // fifo activity
  input  wire ufr_fifo_evt_t evt_i,
  // fill level
  output logic [W-1:0]       level_o
);

  localparam logic [W-1:0] FULL_CNT = W'(DEPTH);

  logic [W-1:0] level_reg;
  logic [W-1:0] level_next;

  // saturate at full, never wrap below empty
  always_comb begin
    level_next = level_reg;
    if (evt_i.push && !evt_i.pop && level_reg != FULL_CNT) begin // RULE_10
      level_next = level_reg + W'(1);
    end else if (evt_i.pop && !evt_i.push && level_reg != '0) begin // RULE_10
      level_next = level_reg - W'(1);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      level_reg <= '0;
    end else begin
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);

  property p_cnt_sat;
    (level_reg == FULL_CNT && evt_i.push && !evt_i.pop) |=> (level_reg == FULL_CNT);
  endproperty
  a_cnt_sat: assert property (p_cnt_sat) else $error("level count passed full"); // RULE_10

  property p_cnt_floor;
    (level_reg == '0 && evt_i.pop && !evt_i.push) |=> (level_reg == '0);
  endproperty
  a_cnt_floor: assert property (p_cnt_floor) else $error("level count wrapped below empty"); // RULE_10

endmodule

// *** dv/ufr_regs_bench.sv ***
`timescale 1ns/1ps
module ufr_regs_bench;
  import ufr_pkg::*;

  logic          clk_sys_i;
  logic          rst_b_i;
  ufr_bus_req_t  bus_req_i;
  logic [7:0]    line_control_register;
  logic [7:0]    rdata_o;
  logic          rdata_valid_o;
  ufr_fifo_evt_t rx_evt_i;
  ufr_fifo_evt_t tx_evt_i;
  logic [6:0]    receive_threshold_o;
  logic [6:0]    transmit_threshold_o;
  logic [1:0]    table_sel_o;
  logic [6:0]    rx_level_o;
  logic [6:0]    tx_level_o;
  int            fail_count;
  int            samples_checked;

  ufr_regs i_dut (
    .clk_sys_i               (clk_sys_i),
    .rst_b_i                 (rst_b_i),
    .bus_req_i               (bus_req_i),
    .line_control_register_i (line_control_register),
    .rdata_o                 (rdata_o),
    .rdata_valid_o           (rdata_valid_o),
    .rx_evt_i                (rx_evt_i),
    .tx_evt_i                (tx_evt_i),
    .receive_threshold_o     (receive_threshold_o),
    .transmit_threshold_o    (transmit_threshold_o),
    .table_sel_o             (table_sel_o),
    .rx_level_o              (rx_level_o),
    .tx_level_o              (tx_level_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  task automatic finish_test;
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // compare and count
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(posedge clk_sys_i);
    #1;
  endtask

  // one-cycle host access, after an idle edge so no signal is set twice in one step
  task automatic bus(input logic rd, input logic wr, input logic [2:0] a, input logic [7:0] d);
    tick();
    bus_req_i = '{cs: 1'h1, rd: rd, wr: wr, addr: a, wdata: d};
    tick();
    bus_req_i = '0;
  endtask

  // answered read with expected data
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    bus(1'h1, 1'h0, a, 8'h00);
    check8({7'h00, rdata_valid_o}, 8'h01);
    check8(rdata_o, exp);
  endtask

  // read that must get no answer
  task automatic rd_none(input logic [2:0] a, input logic [7:0] held);
    bus(1'h1, 1'h0, a, 8'h00);
    check8({7'h00, rdata_valid_o}, 8'h00);
    check8(rdata_o, held);
  endtask

  // two fill count reads on consecutive edges, request held across both
  task automatic rd_pair(input logic [7:0] exp0, input logic [7:0] exp1);
    tick();
    bus_req_i = '{cs: 1'h1, rd: 1'h1, wr: 1'h0, addr: 3'h0, wdata: 8'h00};
    tick();
    check8({7'h00, rdata_valid_o}, 8'h01);
    check8(rdata_o, exp0);
    tick();
    bus_req_i = '0;
    check8({7'h00, rdata_valid_o}, 8'h01);
    check8(rdata_o, exp1);
  endtask

  task automatic evt(input logic rpu, input logic rpo, input logic tpu, input logic tpo, input int n);
    tick();
    rx_evt_i = '{push: rpu, pop: rpo};
    tx_evt_i = '{push: tpu, pop: tpo};
    repeat (n) tick();
    rx_evt_i = '0;
    tx_evt_i = '0;
  endtask

  task automatic t_reset_values;
    rd_chk(3'h1, 8'h20);
    rd_chk(3'h0, 8'h00);
    rd_chk(3'h0, 8'h80);
    check8({1'h0, receive_threshold_o}, 8'h00);
    check8({1'h0, transmit_threshold_o}, 8'h00);
  endtask

  task automatic t_thresholds;
    bus(1'h0, 1'h1, 3'h0, 8'h85);
    check8({1'h0, transmit_threshold_o}, 8'h05);
    check8({1'h0, receive_threshold_o}, 8'h00);
    bus(1'h0, 1'h1, 3'h0, 8'h40);
    check8({1'h0, receive_threshold_o}, 8'h40);
    check8({1'h0, transmit_threshold_o}, 8'h05);
    line_control_register = 8'h3F;
    bus(1'h0, 1'h1, 3'h0, 8'h81);
    tick();
    check8({1'h0, transmit_threshold_o}, 8'h05);
    rd_none(3'h0, 8'h80);
    line_control_register = 8'hBF;
    rd_none(3'h2, 8'h80);
  endtask

  task automatic t_tables;
    for (int t = 0; t < 4; t++) begin
      bus(1'h0, 1'h1, 3'h1, {2'h3, t[1:0], 4'hF});
      check8({6'h00, table_sel_o}, {6'h00, t[1:0]});
      rd_chk(3'h1, {2'h0, t[1:0], 4'h0});
    end
  endtask

  task automatic t_levels;
    evt(1'h1, 1'h0, 1'h1, 1'h0, 3);
    evt(1'h0, 1'h0, 1'h1, 1'h0, 2);
    evt(1'h1, 1'h1, 1'h1, 1'h1, 1);
    rd_chk(3'h0, 8'h03);
    rd_chk(3'h0, 8'h85);
    rd_chk(3'h0, 8'h03);
    rd_pair(8'h85, 8'h03);
    evt(1'h1, 1'h0, 1'h0, 1'h1, 66);
    check8({1'h0, rx_level_o}, 8'h40);
    check8({1'h0, tx_level_o}, 8'h00);
    rd_chk(3'h0, 8'h80);
    rd_chk(3'h0, 8'h40);
    evt(1'h0, 1'h1, 1'h1, 1'h0, 70);
    check8({1'h0, rx_level_o}, 8'h00);
    check8({1'h0, tx_level_o}, 8'h40);
    rd_chk(3'h0, 8'hC0);
  endtask

  initial begin
    fail_count = 0;
    samples_checked = 0;
    rst_b_i = 1'h0;
    bus_req_i = '0;
    line_control_register = 8'hBF;
    rx_evt_i = '0;
    tx_evt_i = '0;
    repeat (20) @(posedge clk_sys_i);
    #1;
    rst_b_i = 1'h1;
    t_reset_values();
    t_thresholds();
    t_tables();
    t_levels();
    finish_test();
  end

  // bound on the whole run
  initial begin
    repeat (100000) @(posedge clk_sys_i);
    fail_count++;
    finish_test();
  end
endmodule
